// >>> tb/scrp_dev_model.sv
`timescale 1ns/100ps
module scrp_dev_model
#(
    parameter logic [15:0] REG_DEF = 16'h0000
)
(
    input  wire logic register_control_select_n,
    input  wire logic serial_select_n,
    input  wire logic sclk,
    input  wire logic serial_in_line,
    input  wire logic serial_in_line_oe,
    output logic      serial_out_line,
    output int        frames,
    output int        last_len,
    output int        proto_errs
);
    logic [15:0] regs [16];
    logic [23:0] sh;
    logic [15:0] rv;
    logic        rd;
    logic        drv;
    logic        obit;
    logic        in_frame;
    int          n;

    // A released line shows the inverse of the last bit, so stale data never reads as valid
    assign serial_out_line = drv ? obit : ~obit;

    initial
    begin
        frames = 0;
        last_len = 0;
        proto_errs = 0;
        n = 0;
        rd = 1'b0;
        drv = 1'b0;
        obit = 1'b0;
        in_frame = 1'b0;
    end

    // Pin control holds the bank at defaults; nothing else clears it, power-down included
    always @(register_control_select_n)
    begin
        if (register_control_select_n !== 1'b0)
        begin
            for (int i = 0; i < 16; i++)
                regs[i] = REG_DEF;
        end
    end

    // Select fall opens a new access
    always @(negedge serial_select_n)
    begin
        n = 0;
        drv = 1'b0;
        in_frame = 1'b1;
    end

    // Select rise ends the access and floats the output; the reset-time rise opens no frame
    always @(posedge serial_select_n)
    begin
        drv = 1'b0;
        if (in_frame)
        begin
            in_frame = 1'b0;
            frames++;
            last_len = n;
            if (sclk !== 1'b0)
                proto_errs++;
        end
    end

    // Input taken on rising edges; a write commits only at the 24th bit
    always @(posedge sclk)
    begin
        if (serial_select_n !== 1'b0)
            proto_errs++;
        else
        begin
            sh = {sh[22:0], serial_in_line};
            n++;
            if (n == 1)
                rd = serial_in_line;
            if (n == 3 && sh[1:0] !== 2'b10)
                proto_errs++;
            if (n == 8)
                rv = (sh[4:1] inside {[4'h0:4'h3], [4'hA:4'hD]}) ? regs[sh[4:1]] : 16'h0000;
            if (n > 8 && rd && serial_in_line_oe !== 1'b0)
                proto_errs++;
            if (n == 24 && !rd && register_control_select_n === 1'b0 && sh[20:17] inside {[4'h0:4'h3], [4'hA:4'hD]})
                regs[sh[20:17]] = sh[15:0];
        end
    end

    // Output changes on falling edges, MSB from the 8th fall, last bit held past 24
    always @(negedge sclk)
    begin
        if (serial_select_n === 1'b0 && rd && n >= 8)
        begin
            drv = 1'b1;
            obit = (n < 24) ? rv[23 - n] : rv[0];
        end
    end
endmodule : scrp_dev_model

// >>> tb/test_serial_control_register_port.sv
`timescale 1ns/100ps
module test_serial_control_register_port;
    localparam logic [15:0] REG_DEF = 16'h0000;
    localparam logic [3:0]  IDX [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hA, 4'hB, 4'hC, 4'hD};
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        register_control_select_n;
    logic        serial_select_n;
    logic        sclk;
    logic        serial_in_line;
    logic        serial_in_line_oe;
    logic        serial_out_line;
    int          frames;
    int          last_len;
    int          proto_errs;
    int          failures;
    int          n_checks;
    int          low_cyc;
    int          f0;
    logic [31:0] q;
    logic        e;

    scrp_host i_scrp_host
    (
        .pclk                      (pclk),
        .presetn                   (presetn),
        .psel                      (psel),
        .penable                   (penable),
        .pwrite                    (pwrite),
        .paddr                     (paddr),
        .pwdata                    (pwdata),
        .prdata                    (prdata),
        .pready                    (pready),
        .pslverr                   (pslverr),
        .register_control_select_n (register_control_select_n),
        .serial_select_n           (serial_select_n),
        .sclk                      (sclk),
        .serial_in_line            (serial_in_line),
        .serial_in_line_oe         (serial_in_line_oe),
        .serial_out_line           (serial_out_line)
    );

    scrp_dev_model #(.REG_DEF(REG_DEF)) i_scrp_dev_model
    (
        .register_control_select_n (register_control_select_n),
        .serial_select_n           (serial_select_n),
        .sclk                      (sclk),
        .serial_in_line            (serial_in_line),
        .serial_in_line_oe         (serial_in_line_oe),
        .serial_out_line           (serial_out_line),
        .frames                    (frames),
        .last_len                  (last_len),
        .proto_errs                (proto_errs)
    );

    // 200 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Counts cycles with the frame select low
    always @(posedge pclk)
        if (serial_select_n === 1'b0)
            low_cyc <= low_cyc + 1;

    task automatic wrap_up;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer, entered just after a rising edge; holds until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (k >= 50)
            failures++;
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Polls until the frame is done, then clears the sticky flag
    task automatic wait_done;
        int k;
        k = 0;
        do
        begin
            apb(1'b0, scrp_pkg::OFS_STATUS, 32'h0);
            k++;
        end
        while (q[scrp_pkg::ST_DONE] !== 1'b1 && k < 1000);
        if (k >= 1000)
            failures++;
        apb(1'b1, scrp_pkg::OFS_STATUS, 32'h2);
    endtask : wait_done

    // One whole access; leaves the captured read data in q
    task automatic frame(input logic r, input logic [3:0] idx, input logic [15:0] d, input int div);
        f0 = frames;
        apb(1'b1, scrp_pkg::OFS_WDATA, {16'h0000, d});
        low_cyc = 0;
        apb(1'b1, scrp_pkg::OFS_CTRL, {23'h0, 1'b1, idx, 2'b00, r, 1'b1});
        wait_done();
        // Lead half, 47 inner halves, trail half, plus one cycle before the divider's first tick
        chk(low_cyc, (2 * scrp_pkg::FRAME_BITS + 1) * div + 1);
        chk(frames - f0, 1);
        chk(last_len, 24);
        apb(1'b0, scrp_pkg::OFS_RDATA, 32'h0);
    endtask : frame

    // Watchdog, well beyond the expected run
    initial
    begin
        #400000;
        failures++;
        wrap_up();
    end

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        failures = 0;
        n_checks = 0;
        low_cyc = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, scrp_pkg::OFS_DIV, 32'h0);
        chk(q, 32'h0000000A);
        chk({31'h0, register_control_select_n}, 32'h1);
        apb(1'b0, 8'h14, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        $display("test reset_values done");
        // Writes to every implemented register first, so a decode slip shows on read-back
        apb(1'b1, scrp_pkg::OFS_CTRL, 32'h00000100);
        chk({31'h0, register_control_select_n}, 32'h0);
        for (int i = 0; i < 8; i++)
            frame(1'b0, IDX[i], {IDX[i], 4'hC, ~IDX[i], 4'h3}, 10);
        for (int i = 0; i < 8; i++)
        begin
            frame(1'b1, IDX[i], 16'hFFFF, 10);
            chk(q, {16'h0, IDX[i], 4'hC, ~IDX[i], 4'h3});
        end
        frame(1'b0, 4'h5, 16'h5AA5, 10);
        frame(1'b1, 4'h5, 16'h0000, 10);
        chk(q, 32'h0);
        $display("test register_access done");
        // Divider at its floor and below it
        apb(1'b1, scrp_pkg::OFS_DIV, 32'h4);
        frame(1'b1, 4'h3, 16'h0000, 4);
        chk(q, 32'h00003CC3);
        apb(1'b1, scrp_pkg::OFS_DIV, 32'h2);
        frame(1'b1, 4'hA, 16'h0000, 4);
        chk(q, 32'h0000AC53);
        apb(1'b1, scrp_pkg::OFS_DIV, 32'hA);
        $display("test divider done");
        // A start while busy is dropped whole
        f0 = frames;
        apb(1'b1, scrp_pkg::OFS_WDATA, 32'h1111);
        apb(1'b1, scrp_pkg::OFS_CTRL, 32'h00000111);
        apb(1'b0, scrp_pkg::OFS_STATUS, 32'h0);
        chk(q, 32'h1);
        apb(1'b1, scrp_pkg::OFS_CTRL, 32'h00000121);
        wait_done();
        apb(1'b0, scrp_pkg::OFS_STATUS, 32'h0);
        chk(q, 32'h0);
        chk(frames - f0, 1);
        frame(1'b1, 4'h1, 16'h0000, 10);
        chk(q, 32'h00001111);
        frame(1'b1, 4'h2, 16'h0000, 10);
        chk(q, 32'h00002CD3);
        $display("test busy_refusal done");
        // Back to pin control resets the bank; a start there is dropped
        apb(1'b1, scrp_pkg::OFS_CTRL, 32'h0);
        chk({31'h0, register_control_select_n}, 32'h1);
        f0 = frames;
        apb(1'b1, scrp_pkg::OFS_CTRL, 32'h00000021);
        repeat (600) @(posedge pclk);
        chk(frames - f0, 0);
        apb(1'b0, scrp_pkg::OFS_STATUS, 32'h0);
        chk(q, 32'h0);
        apb(1'b1, scrp_pkg::OFS_CTRL, 32'h00000100);
        frame(1'b1, 4'h0, 16'h0000, 10);
        chk(q, {16'h0, REG_DEF});
        chk(q & 32'h00004090, 32'h0);
        chk(proto_errs, 0);
        $display("test mode_toggle done");
        wrap_up();
    end
endmodule : test_serial_control_register_port

// >>> verilog/scrp_host.sv
// Our own choice: register access over APB.
`timescale 1ns/100ps
module scrp_host
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             register_control_select_n,
    output logic             serial_select_n,
    output logic             sclk,
    output logic             serial_in_line,
    output logic             serial_in_line_oe,
    input  wire logic        serial_out_line
);
    scrp_tick_if tk ();

    scrp_pkg::scrp_state_t      state_r, state_nxt;
    logic [23:0]                frame_r, frame_nxt;
    logic [15:0]                rx_r, rx_nxt;
    logic [4:0]                 bit_r, bit_nxt;
    logic [7:0]                 gap_r, gap_nxt;
    logic                       cs_n_r, cs_n_nxt;
    logic                       sclk_r, sclk_nxt;
    logic                       oe_r, oe_nxt;
    logic                       rd_r, rd_nxt;
    logic [3:0]                 addr_r, addr_nxt;
    logic                       mode_r, mode_nxt;
    logic [15:0]                wdata_r, wdata_nxt;
    logic [15:0]                rdata_r, rdata_nxt;
    logic [scrp_pkg::DIV_W-1:0] div_r, div_nxt;
    logic                       done_r, done_nxt;
    logic [31:0]                prdata_r, prdata_nxt;
    logic                       sdo_m_r, sdo_s_r;
    logic                       wr_acc, hit, start, frame_end;

    scrp_sclk_div u_div
    (
        .pclk    (pclk),
        .presetn (presetn),
        .tk      (tk)
    );

    // Divider runs only inside a frame; slow rates are just larger counts
    assign tk.run  = (state_r == scrp_pkg::ST_LEAD) || (state_r == scrp_pkg::ST_SHIFT) ||
                     (state_r == scrp_pkg::ST_TRAIL);
    assign tk.half = (div_r < scrp_pkg::DIV_MIN) ? scrp_pkg::DIV_MIN : div_r;

    // Device output comes from another clock domain
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sdo_m_r <= 1'b0;
            sdo_s_r <= 1'b0;
        end
        else
        begin
            sdo_m_r <= serial_out_line;
            sdo_s_r <= sdo_m_r;
        end
    end

    // APB decode; zero wait states, unmapped offsets answer with an error
    assign wr_acc = psel && penable && pwrite;
    always_comb
    begin
        hit = 1'b1;
        if (paddr == scrp_pkg::OFS_CTRL)
            prdata_nxt = {23'h0, mode_r, addr_r, 2'h0, rd_r, 1'b0};
        else if (paddr == scrp_pkg::OFS_WDATA)
            prdata_nxt = {16'h0, wdata_r};
        else if (paddr == scrp_pkg::OFS_RDATA)
            prdata_nxt = {16'h0, rdata_r};
        else if (paddr == scrp_pkg::OFS_STATUS)
            prdata_nxt = {30'h0, done_r, state_r != scrp_pkg::ST_IDLE};
        else if (paddr == scrp_pkg::OFS_DIV)
            prdata_nxt = {24'h0, div_r};
        else
        begin
            hit        = 1'b0;
            prdata_nxt = 32'h0;
        end
        if (!(psel && !penable))
            prdata_nxt = prdata_r;
    end
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata  = prdata_r;

    // Starting needs register mode and an idle engine; else the bit is dropped
    assign start     = wr_acc && (paddr == scrp_pkg::OFS_CTRL) && pwdata[scrp_pkg::CTRL_START] &&
                       pwdata[scrp_pkg::CTRL_REGMODE] && mode_r && (state_r == scrp_pkg::ST_IDLE);
    assign frame_end = (state_r == scrp_pkg::ST_GAP) && (gap_r == 8'h00);

    // Software-facing registers; done set wins over a clear in the same cycle
    always_comb
    begin
        mode_nxt  = mode_r;
        rd_nxt    = rd_r;
        addr_nxt  = addr_r;
        wdata_nxt = wdata_r;
        div_nxt   = div_r;
        done_nxt  = done_r;
        if (wr_acc && paddr == scrp_pkg::OFS_CTRL && state_r == scrp_pkg::ST_IDLE)
        begin
            mode_nxt = pwdata[scrp_pkg::CTRL_REGMODE];
            rd_nxt   = pwdata[scrp_pkg::CTRL_READ];
            addr_nxt = pwdata[scrp_pkg::CTRL_ADDR_HI:scrp_pkg::CTRL_ADDR_LO];
        end
        if (wr_acc && paddr == scrp_pkg::OFS_WDATA)
            wdata_nxt = pwdata[15:0];
        if (wr_acc && paddr == scrp_pkg::OFS_DIV)
            div_nxt = pwdata[7:0];
        if (wr_acc && paddr == scrp_pkg::OFS_STATUS && pwdata[scrp_pkg::ST_DONE])
            done_nxt = 1'b0;
        if (frame_end)
            done_nxt = 1'b1;
    end

    // Frame engine: one tick per half serial clock
    always_comb
    begin
        state_nxt = state_r;
        frame_nxt = frame_r;
        rx_nxt    = rx_r;
        bit_nxt   = bit_r;
        gap_nxt   = gap_r;
        cs_n_nxt  = cs_n_r;
        sclk_nxt  = sclk_r;
        oe_nxt    = oe_r;
        rdata_nxt = rdata_r;
        case (state_r)
            scrp_pkg::ST_IDLE:
            begin
                if (start)
                begin
                    frame_nxt = {pwdata[scrp_pkg::CTRL_READ], scrp_pkg::RSVD_VAL,
                                 pwdata[scrp_pkg::CTRL_ADDR_HI:scrp_pkg::CTRL_ADDR_LO],
                                 1'b0, wdata_r};
                    cs_n_nxt  = 1'b0;
                    oe_nxt    = 1'b1;
                    bit_nxt   = '0;
                    state_nxt = scrp_pkg::ST_LEAD;
                end
            end
            scrp_pkg::ST_LEAD:
            begin
                if (tk.tick)
                begin
                    sclk_nxt  = 1'b1;
                    rx_nxt    = {rx_r[14:0], sdo_s_r};
                    state_nxt = scrp_pkg::ST_SHIFT;
                end
            end
            scrp_pkg::ST_SHIFT:
            begin
                if (tk.tick && sclk_r)
                begin
                    sclk_nxt = 1'b0;
                    if (bit_r == scrp_pkg::LAST_IDX)
                        state_nxt = scrp_pkg::ST_TRAIL;
                    else
                    begin
                        bit_nxt   = bit_r + 5'h01;
                        frame_nxt = {frame_r[22:0], 1'b0};
                        if (rd_r && (bit_r + 5'h01 == scrp_pkg::CMD_IDX))
                            oe_nxt = 1'b0;
                    end
                end
                else if (tk.tick)
                begin
                    // Device launched on the falling edge, so sample on rising
                    sclk_nxt = 1'b1;
                    rx_nxt   = {rx_r[14:0], sdo_s_r};
                end
            end
            scrp_pkg::ST_TRAIL:
            begin
                if (tk.tick)
                begin
                    cs_n_nxt  = 1'b1;
                    oe_nxt    = 1'b0;
                    gap_nxt   = 8'(scrp_pkg::CS_GAP_CYC - 1);
                    if (rd_r)
                        rdata_nxt = rx_r;
                    state_nxt = scrp_pkg::ST_GAP;
                end
            end
            default:
            begin
                if (gap_r == 8'h00)
                    state_nxt = scrp_pkg::ST_IDLE;
                else
                    gap_nxt = gap_r - 8'h01;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r  <= scrp_pkg::ST_IDLE;
            frame_r  <= '0;
            rx_r     <= '0;
            bit_r    <= '0;
            gap_r    <= '0;
            cs_n_r   <= 1'b1;
            sclk_r   <= 1'b0;
            oe_r     <= 1'b0;
            rdata_r  <= '0;
            mode_r   <= 1'b0;
            rd_r     <= 1'b0;
            addr_r   <= '0;
            wdata_r  <= '0;
            div_r    <= scrp_pkg::DIV_RST;
            done_r   <= 1'b0;
            prdata_r <= '0;
        end
        else
        begin
            state_r  <= state_nxt;
            frame_r  <= frame_nxt;
            rx_r     <= rx_nxt;
            bit_r    <= bit_nxt;
            gap_r    <= gap_nxt;
            cs_n_r   <= cs_n_nxt;
            sclk_r   <= sclk_nxt;
            oe_r     <= oe_nxt;
            rdata_r  <= rdata_nxt;
            mode_r   <= mode_nxt;
            rd_r     <= rd_nxt;
            addr_r   <= addr_nxt;
            wdata_r  <= wdata_nxt;
            div_r    <= div_nxt;
            done_r   <= done_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // Pin mode low selects register control; dropping it resets the device bank
    assign register_control_select_n = !mode_r;
    assign serial_select_n           = cs_n_r;
    assign sclk                      = sclk_r;
    assign serial_in_line            = frame_r[23];
    assign serial_in_line_oe         = oe_r;

    // Helper: rising serial edges seen in the current frame
    logic       sclk_q;
    logic [5:0] rise_cnt;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sclk_q   <= 1'b0;
            rise_cnt <= '0;
        end
        else
        begin
            sclk_q <= sclk_r;
            if (cs_n_r)
                rise_cnt <= '0;
            else if (sclk_r && !sclk_q)
                rise_cnt <= rise_cnt + 6'h01;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_mode_before_frame: assert property ($fell(cs_n_r) |-> !register_control_select_n)
        else $error("frame started outside register control");
    chk_frame_length: assert property ($rose(cs_n_r) |-> rise_cnt == 6'd24)
        else $error("frame length not 24 clocks");
    chk_first_bit_ready: assert property ($fell(cs_n_r) |-> !sclk_r && oe_r && serial_in_line == rd_r)
        else $error("first bit not ready at select fall");
    chk_select_gap: assert property ($rose(cs_n_r) |-> cs_n_r [*8])
        else $error("select gap too short");
    chk_clock_parked: assert property (cs_n_r |-> !sclk_r)
        else $error("serial clock not parked low");
    chk_direction_bit: assert property (sclk_r && !sclk_q && rise_cnt == 6'd0 |-> serial_in_line == rd_r)
        else $error("direction bit wrong");
    chk_reserved_pair: assert property (sclk_r && !sclk_q && (rise_cnt == 6'd1 || rise_cnt == 6'd2) |->
                                        serial_in_line == (rise_cnt == 6'd1))
        else $error("reserved bits not 10");
    chk_index_bits: assert property (sclk_r && !sclk_q && rise_cnt >= 6'd3 && rise_cnt <= 6'd6 |->
                                     serial_in_line == addr_r[6 - rise_cnt])
        else $error("register index bits wrong");
    chk_read_release: assert property (!cs_n_r && rd_r && rise_cnt >= 6'd8 && !sclk_r |-> !oe_r)
        else $error("host drives line during read data");
    chk_read_capture: assert property ($rose(cs_n_r) && rd_r |-> rdata_r == $past(rx_r))
        else $error("read data not captured");

    cov_read_frame:  cover property ($rose(cs_n_r) && rd_r);
    cov_write_frame: cover property ($rose(cs_n_r) && !rd_r);
    cov_start_refused: cover property (wr_acc && paddr == scrp_pkg::OFS_CTRL && pwdata[0] && !start);
    cov_done_clear_race: cover property (frame_end && wr_acc && paddr == scrp_pkg::OFS_STATUS);
endmodule : scrp_host

// >>> verilog/scrp_pkg.sv
package scrp_pkg;

    // Clock and link timing
    localparam int PCLK_PERIOD_NS  = 5;
    localparam int SCLK_HALF_NS    = 50;
    localparam int CS_GAP_NS       = 100;
    localparam int SCLK_HALF_CYC   = (SCLK_HALF_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
    localparam int CS_GAP_CYC      = (CS_GAP_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
    localparam int DIV_W           = 8;
    localparam logic [7:0] DIV_MIN = 8'h04;
    localparam logic [7:0] DIV_RST = 8'(SCLK_HALF_CYC);

    // Frame layout, bit 1 of the frame is the top bit of the shifter
    localparam int FRAME_BITS      = 24;
    localparam int CMD_BITS        = 8;
    localparam int DATA_BITS       = 16;
    localparam logic [1:0] RSVD_VAL = 2'h2;
    localparam logic [4:0] LAST_IDX = 5'h17;
    localparam logic [4:0] CMD_IDX  = 5'h08;
    localparam logic FRAME_READ    = 1'h1;
    localparam logic FRAME_WRITE   = 1'h0;

    // Own APB register map
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_WDATA  = 8'h04;
    localparam logic [7:0] OFS_RDATA  = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_DIV    = 8'h10;

    // Control and status fields
    localparam int CTRL_START    = 0;
    localparam int CTRL_READ     = 1;
    localparam int CTRL_ADDR_LO  = 4;
    localparam int CTRL_ADDR_HI  = 7;
    localparam int CTRL_REGMODE  = 8;
    localparam int ST_BUSY       = 0;
    localparam int ST_DONE       = 1;

    // Device register indices and main configuration fields
    localparam logic [3:0] DEV_MAIN_CFG     = 4'h0;
    localparam logic [3:0] DEV_CM_ADJ       = 4'h1;
    localparam logic [3:0] DEV_OFS_FIRST    = 4'h2;
    localparam logic [3:0] DEV_FS_FIRST     = 4'h3;
    localparam logic [3:0] DEV_OFS_SECOND   = 4'hA;
    localparam logic [3:0] DEV_FS_SECOND    = 4'hB;
    localparam logic [3:0] DEV_PHASE_COARSE = 4'hC;
    localparam logic [3:0] DEV_PHASE_FILT   = 4'hD;
    localparam int CFG_INTERLEAVE_BIT = 7;
    localparam int CFG_PHASE_BIT      = 14;
    localparam int CFG_TWOS_BIT       = 4;

    typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_TRAIL, ST_GAP} scrp_state_t;

endpackage : scrp_pkg

// >>> verilog/scrp_sclk_div.sv
`timescale 1ns/100ps
module scrp_sclk_div
(
    input  wire logic    pclk,
    input  wire logic    presetn,
    scrp_tick_if.gen     tk
);
    logic [scrp_pkg::DIV_W-1:0] cnt_r;
    logic [scrp_pkg::DIV_W-1:0] cnt_nxt;
    logic                       tick_r;
    logic                       tick_nxt;

    // Counter restarts whenever run drops, so each frame starts phase-aligned
    always_comb
    begin
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (!tk.run)
            cnt_nxt = '0;
        else if (cnt_r >= tk.half - 8'h01)
        begin
            cnt_nxt  = '0;
            tick_nxt = 1'b1;
        end
        else
            cnt_nxt = cnt_r + 8'h01;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tk.tick = tick_r & tk.run;
endmodule : scrp_sclk_div

// >>> verilog/scrp_tick_if.sv
`timescale 1ns/100ps
interface scrp_tick_if;
    logic                     run;
    logic [scrp_pkg::DIV_W-1:0] half;
    logic                     tick;
    modport gen (input run, input half, output tick);
    modport use_side (output run, output half, input tick);
endinterface : scrp_tick_if
